/* File: src/pulse_ref_decoder.sv */
// Pulse reference decoder with speed coincidence output and Avalon-MM register slave.
// What this block does
// - Flags on an output terminal when the measured motor speed agrees with the commanded speed.
// - The speed match indication is low when speeds agree and high when they do not.
// - Speeds agree when their absolute difference is below the window, 0 to 100 rpm, reset 10, applied at once.
// - The speed match indication is only produced in speed control mode.
// - In position control the default terminal shows positioning complete instead of speed match.
// - The speed match indication goes to the terminal picked by the output allocation setting.
// - Control mode digit 1 selects pulse train position control, applied only at a restart.
// - Input form 0 is pulse plus sign, 1 is forward and reverse lines, 2 to 4 are quadrature.
// - Quadrature forms 2, 3 and 4 count at x1, x2 and x4; other forms have no multiplier.
// - Inversion digit 0 inverts no line and 3 inverts both, applied at a restart.
// - Inversion digit 1 inverts only the sign line and 2 inverts only the pulse line.
// - In pulse plus sign form a high sign line means forward and a low one reverse.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
module pulse_ref_decoder
  import pulse_ref_pkg::*;
#(
  parameter int SPEED_W = 16,
  parameter int COUNT_W = 32,
  parameter int N_TERM  = 4
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic [4:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic                      pulse_pin,
  input  wire logic                      sign_pin,
  input  wire logic signed [SPEED_W-1:0] motor_speed,
  input  wire logic signed [SPEED_W-1:0] command_speed,
  input  wire logic                      position_done,
  output logic      [N_TERM-1:0]         out_terminal_n,
  output logic                           ref_up,
  output logic                           ref_down,
  output logic      [COUNT_W-1:0]        ref_count
);
  // Absolute difference of two signed speeds, one bit wider so it never wraps.
  function automatic logic [SPEED_W:0] abs_diff(input logic signed [SPEED_W-1:0] x,
                                                input logic signed [SPEED_W-1:0] y);
    logic signed [SPEED_W:0] d;
    d = (SPEED_W+1)'(x) - (SPEED_W+1)'(y);
    abs_diff = d[SPEED_W] ? $unsigned(-d) : $unsigned(d);
  endfunction

  logic [3:0]                pend_mode;
  logic [2:0]                pend_form;
  logic [1:0]                pend_inv;
  logic [3:0]                act_mode;
  logic [2:0]                act_form;
  logic [1:0]                act_inv;
  logic [6:0]                speed_match_window;
  logic [$clog2(N_TERM)-1:0] output_allocation_param;
  logic                      sync_a1;
  logic                      sync_a2;
  logic                      sync_b1;
  logic                      sync_b2;
  logic                      prev_a;
  logic                      prev_b;

  // Bus decode: a transfer completes at the edge where the request meets a low waitrequest.
  wire bus_req    = avs_read | avs_write;
  wire wr_go      = avs_write & ~avs_waitrequest;
  wire wr_config  = wr_go & (avs_address == OFS_CONFIG);
  wire wr_window  = wr_go & (avs_address == OFS_WINDOW);
  wire wr_alloc   = wr_go & (avs_address == OFS_ALLOC);
  wire do_restart = wr_go & (avs_address == OFS_RESTART);

  // Window writes above the top of the range are held at the top.
  wire [6:0] next_window = (avs_writedata[31:7] != 25'h0000000 || avs_writedata[6:0] > WINDOW_MAX) ?
                           WINDOW_MAX : avs_writedata[6:0];

  // Speed comparison and the two active-low indications.
  wire is_close        = abs_diff(motor_speed, command_speed) < (SPEED_W+1)'(speed_match_window);
  wire speed_mode      = act_mode == MODE_SPEED;
  wire pos_mode        = act_mode == MODE_POSITION;
  wire speed_match_n   = ~is_close;
  wire position_done_n = ~position_done;

  // Terminal routing: speed match on the allocated terminal, positioning on the default one.
  logic [N_TERM-1:0] next_terminal_n;
  always_comb begin
    next_terminal_n = '1;
    if (speed_mode) begin
      next_terminal_n[output_allocation_param] = speed_match_n;
    end else if (pos_mode) begin
      next_terminal_n[TERMINAL_DEFAULT] = position_done_n;
    end
  end

  // Line polarity: the previous raw level is seen through the current inversion so a restart makes no edge.
  wire step_pulse_line = sync_a2 ^ act_inv[INV_PULSE_BIT];
  wire direction_line  = sync_b2 ^ act_inv[INV_DIR_BIT];
  wire prev_pulse      = prev_a ^ act_inv[INV_PULSE_BIT];
  wire prev_dir        = prev_b ^ act_inv[INV_DIR_BIT];
  wire forward_pulse_line = step_pulse_line;
  wire reverse_pulse_line = direction_line;
  wire a_rise = step_pulse_line & ~prev_pulse;
  wire a_edge = step_pulse_line ^ prev_pulse;
  wire b_edge = direction_line ^ prev_dir;
  wire fwd_rise = forward_pulse_line & ~prev_pulse;
  wire rev_rise = reverse_pulse_line & ~prev_dir;
  wire quad_fwd = ~(step_pulse_line ^ prev_dir);

  // Count events per input form; forms above 4 produce no counts.
  wire quad_step = (act_form == FORM_QUAD_X1) ? a_rise :
                   (act_form == FORM_QUAD_X2) ? a_edge :
                   (act_form == FORM_QUAD_X4) ? (a_edge ^ b_edge) : 1'b0;
  wire next_up = ~pos_mode ? 1'b0 :
                 (act_form == FORM_STEP_DIR) ? (a_rise & direction_line) :
                 (act_form == FORM_FWD_REV) ? (fwd_rise & ~rev_rise) :
                 (quad_step & quad_fwd);
  wire next_dn = ~pos_mode ? 1'b0 :
                 (act_form == FORM_STEP_DIR) ? (a_rise & ~direction_line) :
                 (act_form == FORM_FWD_REV) ? (rev_rise & ~fwd_rise) :
                 (quad_step & ~quad_fwd);

  // Read data selection; unmapped addresses read as zero.
  wire [31:0] cfg_word  = 32'({pend_inv, 1'b0, pend_form, pend_mode});
  // Status layout: agree in bit 0, done in bit 1, mode from bit 4, form from bit 8, inversion from bit 12.
  wire [31:0] stat_word = 32'({act_inv, 1'b0, act_form, act_mode, 2'h0, ~position_done_n, is_close});
  wire [31:0] rd_mux = (avs_address == OFS_CONFIG) ? cfg_word :
                       (avs_address == OFS_WINDOW) ? 32'(speed_match_window) :
                       (avs_address == OFS_ALLOC)  ? 32'(output_allocation_param) :
                       (avs_address == OFS_STATUS) ? stat_word :
                       (avs_address == OFS_COUNT)  ? 32'(ref_count) : 32'h00000000;

  // Bus handshake: one wait cycle, then a single cycle with waitrequest low.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // Settings held for the next restart, and the settings that act at once.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_mode               <= MODE_SPEED;
      pend_form               <= FORM_STEP_DIR;
      pend_inv                <= 2'h0;
      speed_match_window      <= WINDOW_RESET;
      output_allocation_param <= '0;
    end else begin
      if (wr_config) begin
        pend_mode <= avs_writedata[CFG_MODE_LSB +: 4];
        pend_form <= avs_writedata[CFG_FORM_LSB +: 3];
        pend_inv  <= avs_writedata[CFG_INV_LSB +: 2];
      end
      if (wr_window) begin
        speed_match_window <= next_window;
      end
      if (wr_alloc) begin
        output_allocation_param <= avs_writedata[$clog2(N_TERM)-1:0];
      end
    end
  end

  // Active settings change only at reset or at a restart.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      act_mode <= MODE_SPEED;
      act_form <= FORM_STEP_DIR;
      act_inv  <= 2'h0;
    end else if (do_restart) begin
      act_mode <= pend_mode;
      act_form <= pend_form;
      act_inv  <= pend_inv;
    end
  end

  // Two-stage synchronisers on the pins, then a third stage for edge detection.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_a1 <= 1'b0;
      sync_a2 <= 1'b0;
      sync_b1 <= 1'b0;
      sync_b2 <= 1'b0;
      prev_a  <= 1'b0;
      prev_b  <= 1'b0;
    end else begin
      sync_a1 <= pulse_pin;
      sync_a2 <= sync_a1;
      sync_b1 <= sign_pin;
      sync_b2 <= sync_b1;
      prev_a  <= sync_a2;
      prev_b  <= sync_b2;
    end
  end

  // Registered outputs: terminals, count strobes and the reference position.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      out_terminal_n <= '1;
      ref_up         <= 1'b0;
      ref_down       <= 1'b0;
      ref_count      <= '0;
    end else begin
      out_terminal_n <= next_terminal_n;
      ref_up         <= next_up;
      ref_down       <= next_dn;
      if (next_up) begin
        ref_count <= ref_count + COUNT_W'(1);
      end else if (next_dn) begin
        ref_count <= ref_count - COUNT_W'(1);
      end
    end
  end

  // Checks on the decoder, the terminals and the bus.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Speed match terminal: low on the allocated terminal when speeds agree.
  a_match_on_agree: assert property (speed_mode && is_close |=> !out_terminal_n[$past(output_allocation_param)])
    else $error("speed match not driven low while speeds agree");

  // In speed mode every terminal stays high while speeds disagree.
  a_match_off_apart: assert property (speed_mode && !is_close |=> &out_terminal_n)
    else $error("a terminal is low while speeds disagree");

  // The stored window never leaves its range.
  a_window_limit: assert property (speed_match_window <= WINDOW_MAX)
    else $error("speed window above its range");

  // A window write acts on the very next cycle, clamped to the top.
  a_window_apply: assert property (wr_window |=> speed_match_window == $past(next_window))
    else $error("window write did not take effect at once");

  // Modes other than speed and position leave all terminals off.
  a_other_mode_idle: assert property (!speed_mode && !pos_mode |=> &out_terminal_n)
    else $error("terminal active outside speed and position modes");

  // Position mode shows positioning complete on the default terminal.
  a_done_terminal: assert property (pos_mode |=> out_terminal_n[TERMINAL_DEFAULT] == !$past(position_done))
    else $error("default terminal does not follow positioning complete");

  // At most one terminal is active in speed mode.
  a_alloc_single: assert property (speed_mode |=> $onehot0(~out_terminal_n))
    else $error("more than one terminal active in speed mode");

  // Mode, form and inversion change only at a restart.
  a_mode_restart: assert property (!do_restart |=> $stable(act_mode) && $stable(act_form) && $stable(act_inv))
    else $error("active setting changed without a restart");

  // No count strobe leaves the block outside position control.
  a_count_gated: assert property (!pos_mode |=> !ref_up && !ref_down)
    else $error("count strobe outside position control");

  // Pulse plus sign counts in the direction given by the sign line.
  a_step_dir: assert property (pos_mode && act_form == FORM_STEP_DIR && a_rise |=> ref_up == $past(direction_line))
    else $error("pulse plus sign counted the wrong way");

  // Form codes above the quadrature range count nothing.
  a_form_none: assert property (pos_mode && act_form > FORM_QUAD_X4 |=> !ref_up && !ref_down)
    else $error("count strobe in an unused input form");

  // x1 quadrature counts only on a phase A rise.
  a_quad_x1_fall: assert property (pos_mode && act_form == FORM_QUAD_X1 && !a_rise |=> !ref_up && !ref_down)
    else $error("x1 quadrature counted without a phase A rise");

  // x2 quadrature counts on both phase A edges.
  a_quad_x2_edge: assert property (pos_mode && act_form == FORM_QUAD_X2 && a_edge |=> ref_up || ref_down)
    else $error("x2 quadrature missed a phase A edge");

  // Quadrature direction follows the phase order.
  a_quad_dir: assert property (pos_mode && act_form == FORM_QUAD_X4 && a_edge && !b_edge |=> ref_up == $past(quad_fwd))
    else $error("quadrature direction wrong");

  // Inversion code 2 flips only the pulse line.
  a_inv_pulse: assert property (act_inv == 2'h2 |-> step_pulse_line != sync_a2 && direction_line == sync_b2)
    else $error("inversion code 2 applied to the wrong line");

  // The count moves up in the same edge as the up strobe.
  a_fwd_rev_count: assert property (ref_up |-> ref_count == $past(ref_count) + COUNT_W'(1))
    else $error("reference count did not step up");

  // The count moves down in the same edge as the down strobe.
  a_rev_count: assert property (ref_down |-> ref_count == $past(ref_count) - COUNT_W'(1))
    else $error("reference count did not step down");

  // Up and down strobes never appear together.
  a_strobe_excl: assert property (!(ref_up && ref_down))
    else $error("up and down strobes together");

  // Each request is answered after exactly one wait cycle.
  a_bus_wait: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after the request");

  // Main scenarios that the bench is expected to reach.
  c_speed_match: cover property (speed_mode && is_close ##1 !out_terminal_n[output_allocation_param]);
  c_quad_down: cover property (pos_mode && act_form == FORM_QUAD_X4 ##1 ref_down);
  c_restart_pos: cover property (do_restart && pend_mode == MODE_POSITION ##1 pos_mode);
  c_fwd_rev: cover property (pos_mode && act_form == FORM_FWD_REV ##1 ref_down);
  c_step_up: cover property (pos_mode && act_form == FORM_STEP_DIR ##1 ref_up);
endmodule

/* File: src/pulse_ref_pkg.sv */
// Package holding the register map, field layout, codes and reset values of the pulse reference decoder.
package pulse_ref_pkg;
  // Byte addresses of the registers on the Avalon-MM slave.
  localparam logic [4:0] OFS_CONFIG  = 5'h00;
  localparam logic [4:0] OFS_WINDOW  = 5'h04;
  localparam logic [4:0] OFS_ALLOC   = 5'h08;
  localparam logic [4:0] OFS_RESTART = 5'h0c;
  localparam logic [4:0] OFS_STATUS  = 5'h10;
  localparam logic [4:0] OFS_COUNT   = 5'h14;
  // Field positions inside the configuration word.
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_FORM_LSB = 4;
  localparam int CFG_INV_LSB  = 8;
  // Control mode digit codes.
  localparam logic [3:0] MODE_SPEED    = 4'h0;
  localparam logic [3:0] MODE_POSITION = 4'h1;
  // Input form digit codes.
  localparam logic [2:0] FORM_STEP_DIR = 3'h0;
  localparam logic [2:0] FORM_FWD_REV  = 3'h1;
  localparam logic [2:0] FORM_QUAD_X1  = 3'h2;
  localparam logic [2:0] FORM_QUAD_X2  = 3'h3;
  localparam logic [2:0] FORM_QUAD_X4  = 3'h4;
  // Bits of the line inversion digit.
  localparam int INV_DIR_BIT   = 0;
  localparam int INV_PULSE_BIT = 1;
  // Speed window limits and reset value, in rpm.
  localparam logic [6:0] WINDOW_RESET = 7'h0a;
  localparam logic [6:0] WINDOW_MAX   = 7'h64;
  // Terminal that carries the positioning indication.
  localparam logic [1:0] TERMINAL_DEFAULT = 2'h0;
  // Status word bit positions.
  localparam int STAT_MATCH_BIT = 0;
  localparam int STAT_DONE_BIT  = 1;
  localparam int STAT_MODE_LSB  = 4;
  localparam int STAT_FORM_LSB  = 8;
  localparam int STAT_INV_LSB   = 12;
endpackage

/* File: tb/pulse_host_model.sv */
// Host controller model that issues reference pulse trains to the decoder.
module pulse_host_model (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic       fwd,
  input  wire logic [2:0] form,
  input  wire logic [1:0] inv,
  output logic            busy      = 1'b0,
  output logic            pulse_pin = 1'b0,
  output logic            sign_pin  = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic a;
  logic b;
  logic on;
  // One move is four phases of four cycles, so each level outlasts the input synchroniser.
  always begin
    @(posedge ref_clk);
    if (rst) begin
      pulse_pin <= inv[1];
      sign_pin  <= inv[0];
    end else if (go) begin
      busy <= 1'b1;
      for (int i = 0; i < 4; i++) begin
        on = (i == 1) || (i == 2);
        if (form == 3'h0) begin
          a = on;
          b = fwd; // A high sign line asks for forward travel.
        end else if (form == 3'h1) begin
          a = on & fwd;
          b = on & !fwd;
        end else begin
          a = fwd ? on : (i < 2);
          b = fwd ? (i < 2) : on;
        end
        pulse_pin <= a ^ inv[1];
        sign_pin  <= b ^ inv[0];
        repeat (4) @(posedge ref_clk);
      end
      busy <= 1'b0;
    end
  end
endmodule

/* File: tb/tb_pulse_reference_decoder.sv */
// Self-checking bench for the pulse reference decoder.
module tb_pulse_reference_decoder import pulse_ref_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic               ref_clk       = 1'b0;
  logic               rst           = 1'b1;
  logic [4:0]         avs_address   = 5'h00;
  logic               avs_read      = 1'b0;
  logic               avs_write     = 1'b0;
  logic [31:0]        avs_writedata = 32'h0;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic               pulse_pin;
  logic               sign_pin;
  logic signed [15:0] motor_speed   = 16'h0000;
  logic signed [15:0] command_speed = 16'h0000;
  logic               position_done = 1'b0;
  logic [3:0]         out_terminal_n;
  logic               ref_up;
  logic               ref_down;
  logic [31:0]        ref_count;
  logic               go            = 1'b0;
  logic               fwd           = 1'b0;
  logic               busy;
  logic [2:0]         form          = 3'h0;
  logic [1:0]         inv           = 2'h0;
  logic               pd            = 1'b0;
  logic [31:0]        exp_q [$];
  string              name_q [$];
  int                 fails           = 0;
  int                 samples_checked = 0;
  int                 n_up            = 0;
  int                 n_dn            = 0;
  int                 seed            = 32'h692ced86;
  logic [3:0]         tmode [8] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h0};
  logic [2:0]         tform [8] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h4};
  logic [1:0]         tinv  [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h1, 2'h0, 2'h0};
  int                 tu    [8] = '{1, 1, 1, 1, 2, 4, 0, 0};

  pulse_ref_decoder dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pulse_pin(pulse_pin), .sign_pin(sign_pin),
    .motor_speed(motor_speed), .command_speed(command_speed), .position_done(position_done),
    .out_terminal_n(out_terminal_n), .ref_up(ref_up), .ref_down(ref_down), .ref_count(ref_count));
  pulse_host_model host (.ref_clk(ref_clk), .rst(rst), .go(go), .fwd(fwd), .form(form), .inv(inv),
    .busy(busy), .pulse_pin(pulse_pin), .sign_pin(sign_pin));

  // Clock and a watchdog that cuts a hang short.
  initial forever #12.5 ref_clk = ~ref_clk;
  initial begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    results();
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // One Avalon-MM transfer, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      results();
    end
  endtask

  task automatic rd(input string what, input logic [4:0] a, input logic [31:0] want);
    exp_q.push_back(want);
    name_q.push_back(what);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Sends one move through the host model and waits until it has finished.
  task automatic move(input logic dir);
    int n;
    n = 0;
    fwd <= dir;
    go  <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (busy !== 1'b0 && n < 64);
    if (busy !== 1'b0) begin
      fails++;
      results();
    end
  endtask

  // Random speeds just inside or at the window, on the chosen terminal.
  task automatic speed_case(input logic [1:0] t);
    int w;
    int c;
    int d;
    logic ag;
    logic [3:0] term;
    w = {$random(seed)} % 101;
    d = w - ({$random(seed)} % 2);
    if ($random(seed) & 1) d = -d;
    c = $random(seed) % 2000;
    pd = 1'($random(seed));
    bus(1'b1, OFS_ALLOC, {30'h0, t});
    bus(1'b1, OFS_WINDOW, 32'(w));
    command_speed <= 16'(c);
    motor_speed   <= 16'(c + d);
    position_done <= pd;
    ag = ((d < 0) ? -d : d) < w;
    term = 4'hf;
    term[t] = !ag;
    repeat (3) @(posedge ref_clk);
    chk("terminals", {28'h0, out_terminal_n}, {28'h0, term});
    rd("status", OFS_STATUS, {30'h0, pd, ag});
  endtask

  // Counts the up and down strobes seen on the outputs.
  always @(posedge ref_clk) begin
    if (ref_up === 1'b1) n_up <= n_up + 1;
    if (ref_down === 1'b1) n_dn <= n_dn + 1;
  end

  // Compares each read as it completes with the oldest noted value.
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      chk(name_q.pop_front(), avs_readdata, exp_q.pop_front());
    end
  end

  initial begin
    int cnt;
    logic dir;
    int b_up;
    int b_dn;
    int up_exp;
    int dn_exp;
    do_reset();
    rd("window", OFS_WINDOW, 32'h0000000a);
    rd("unmapped", 5'h18, 32'h0);
    for (int t = 0; t < 8; t++) speed_case(2'(t));
    bus(1'b1, OFS_WINDOW, 32'h000000c8);
    rd("window", OFS_WINDOW, 32'h00000064);
    motor_speed <= command_speed;
    $display("test speed match done");
    bus(1'b1, OFS_CONFIG, 32'h1);
    rd("status", OFS_STATUS, {30'h0, pd, 1'b1});
    bus(1'b1, OFS_RESTART, 32'h0);
    position_done <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("terminals", {28'h0, out_terminal_n}, 32'he);
    position_done <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("terminals", {28'h0, out_terminal_n}, 32'hf);
    $display("test position terminal done");
    for (int k = 0; k < 8; k++) begin
      inv  <= tinv[k];
      form <= tform[k];
      do_reset();
      bus(1'b1, OFS_CONFIG, {22'h0, tinv[k], 1'b0, tform[k], tmode[k]});
      bus(1'b1, OFS_RESTART, 32'h0);
      cnt = 0;
      up_exp = 0;
      dn_exp = 0;
      b_up = n_up;
      b_dn = n_dn;
      for (int j = 0; j < 4; j++) begin
        dir = 1'($random(seed));
        move(dir);
        cnt = dir ? cnt + tu[k] : cnt - tu[k];
        if (dir) up_exp = up_exp + tu[k];
        else dn_exp = dn_exp + tu[k];
      end
      repeat (6) @(posedge ref_clk);
      chk("count port", ref_count, 32'(cnt));
      chk("up strobes", 32'(n_up - b_up), 32'(up_exp));
      chk("down strobes", 32'(n_dn - b_dn), 32'(dn_exp));
      rd("count", OFS_COUNT, 32'(cnt));
      rd("status", OFS_STATUS, {18'h0, tinv[k], 1'b0, tform[k], tmode[k], 4'h1});
    end
    $display("test input forms done");
    @(posedge ref_clk);
    results();
  end
endmodule
